/* csc_pkg.sv */
/*
  constants shared by the charger status and control register bank:
  register pointers, field positions, reset values and state codes.
  assumes nothing of its surroundings.
*/
package csc_pkg;

  // fixed seven-bit slave address on the two-wire port
  localparam logic [6:0] SLAVE_ADDR = 7'h36;

  // register pointers
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CHARGER_CONTROL_ONE = 8'h01;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // status register fields
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_BATFET = 3;
  localparam int STAT_NTC = 2;
  localparam int STAT_IRQ = 1;
  localparam int STAT_FAULT_IRQ = 0;

  // control register one fields
  localparam int CTL_SOFT_RST = 7;
  localparam int CTL_CHARGE_EN = 6;
  localparam int CTL_BOOST_REQ = 5;
  localparam int CTL_NTC_EN = 4;
  localparam int CTL_JUNC_DERATE = 3;
  localparam int CTL_WARM_REDUCE = 2;
  localparam int CTL_TCHG_RST = 1;
  localparam int CTL_IRQ_MASK = 0;
  localparam logic [7:0] CHARGER_CONTROL_ONE_RESET = 8'h51;

  // byte framing on the link
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // charger and boost state codes reported in the status register
  typedef enum logic [3:0] {
    CSC_OFF = 4'h0,
    CSC_WAIT = 4'h1,
    CSC_SAFE = 4'h2,
    CSC_PRE = 4'h3,
    CSC_FULL = 4'h4,
    CSC_VOLT = 4'h5,
    CSC_DONE = 4'h6,
    CSC_DPP = 4'h7,
    CSC_WEAK_WAIT = 4'h8,
    CSC_WEAK_SAFE = 4'h9,
    CSC_WEAK_CHG = 4'ha,
    CSC_FAULT = 4'hb,
    CSC_BST_WAIT = 4'hc,
    CSC_BST_FAULT = 4'hd,
    CSC_BST_OL = 4'hf
  } csc_chg_state_t;

  // upper two bits of every boost state code
  localparam logic [1:0] BOOST_GROUP = 2'h3;

endpackage

/* csc_xfer_if.sv */
/*
  carrier for one word passed from one clock domain to another.
  assumes the sender holds off while busy is high.
*/
`timescale 1ns/1ps
interface csc_xfer_if #(parameter int W = 16) ();
  logic send; // sender offers src_data this cycle
  logic busy; // previous word still in flight
  logic [W-1:0] src_data; // word in sender domain
  logic recv; // one-cycle pulse in receiver domain
  logic [W-1:0] dst_data; // word in receiver domain, valid with recv

  modport cdc (input send, input src_data, output busy, output recv, output dst_data);
  modport src (output send, output src_data, input busy);
  modport dst (input recv, input dst_data);
endinterface

/* csc_cdc_word.sv */
/*
  toggle handshake that carries a held word between two clock domains.
  assumes both resets are asynchronous active low and the sender obeys busy.
*/
`timescale 1ns/1ps
module csc_cdc_word (
  input wire logic src_clk_i, // sender clock
  input wire logic src_rst_n_i, // sender reset
  input wire logic dst_clk_i, // receiver clock
  input wire logic dst_rst_n_i, // receiver reset
  csc_xfer_if.cdc x // word carrier
);
  localparam int W = $bits(x.src_data);

  if (W < 1) begin : g_chk
    $error("csc_cdc_word needs a word of at least one bit");
  end

  logic req_q, ack_q, ack_m_q, ack_s_q;
  logic req_m_q, req_s_q, req_p_q, recv_q;
  logic [W-1:0] hold_q, data_q;

  assign x.busy = req_q ^ ack_s_q;
  assign x.recv = recv_q;
  assign x.dst_data = data_q;

  // sender: hold the word and flip the request
  always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
    if (!src_rst_n_i) begin
      req_q <= 1'b0;
      hold_q <= '0;
    end else if (x.send && !x.busy) begin
      req_q <= ~req_q;
      hold_q <= x.src_data;
    end
  end

  // sender: acknowledge brought back over two flops
  always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
    if (!src_rst_n_i) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end else begin
      ack_m_q <= ack_q;
      ack_s_q <= ack_m_q;
    end
  end

  // receiver: request over two flops, edge gives the pulse and the capture
  always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
    if (!dst_rst_n_i) begin
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
      req_p_q <= 1'b0;
      ack_q <= 1'b0;
      recv_q <= 1'b0;
      data_q <= '0;
    end else begin
      req_m_q <= req_q;
      req_s_q <= req_m_q;
      req_p_q <= req_s_q;
      ack_q <= req_s_q;
      recv_q <= req_s_q ^ req_p_q;
      if (req_s_q ^ req_p_q) begin
        data_q <= hold_q;
      end
    end
  end

  // a word arrives as a single pulse
  property p_recv_pulse;
    @(posedge dst_clk_i) disable iff (!dst_rst_n_i) recv_q |=> !recv_q;
  endproperty
  a_recv_pulse: assert property (p_recv_pulse) else $error("receive pulse longer than one cycle");

  // an accepted word keeps the sender busy until the acknowledge returns
  property p_busy_after_send;
    @(posedge src_clk_i) disable iff (!src_rst_n_i) (x.send && !x.busy) |=> x.busy;
  endproperty
  a_busy_after_send: assert property (p_busy_after_send) else $error("sender not busy after send");
endmodule

/* csc_regs.sv */
/*
  charger status and first control register behind a two-wire slave port.
  the link engine runs on LCLK_I and oversamples SCL_I and SDA_I; the
  registers run on MCLK_I. status inputs come from logic on MCLK_I.
*/
`timescale 1ns/1ps
module csc_regs #(
  parameter logic [6:0] SLAVE_ADDR = csc_pkg::SLAVE_ADDR
) (
  input wire logic MCLK_I, // register clock
  input wire logic RST_N_I, // asynchronous reset, active low
  input wire logic LCLK_I, // link oversampling clock
  input wire logic SCL_I, // bus clock pin
  input wire logic SDA_I, // bus data pin level
  output logic SDA_O, // bus data drive value, always low
  output logic SDA_OE_O, // high while pulling bus data low
  input wire logic [3:0] STATE_I, // charger or boost state code
  input wire logic BATFET_DET_I, // isolation transistor detected
  input wire logic NTC_DET_I, // thermistor detected
  input wire logic STAT_IRQ_PEND_I, // status interrupt register non-empty
  input wire logic FAULT_IRQ_PEND_I, // fault or boost interrupt pending
  input wire logic OTG_PIN_I, // boost request pin
  output logic REGS_RST_O, // pulse: reset all registers
  output logic CHARGE_EN_O, // charging enabled
  output logic BOOST_REQ_O, // boost operation requested
  output logic NTC_EN_O, // battery temperature shapes charging
  output logic JUNC_DERATE_O, // reduce current at high junction heat
  output logic WARM_REDUCE_O, // warm battery: reduce instead of hold
  output logic TCHG_RST_O, // pulse: restart charge safety timer
  output logic IRQ_MASK_O, // global interrupt mask
  output logic FLAG_O // interrupt signalled
);
  if (SLAVE_ADDR == 7'h00) begin : g_chk
    $error("csc_regs slave address zero is the general call");
  end

  typedef enum logic [6:0] {
    L_IDLE = 7'h01,
    L_ADDR = 7'h02,
    L_AACK = 7'h04,
    L_WBYTE = 7'h08,
    L_WACK = 7'h10,
    L_RBYTE = 7'h20,
    L_RACK = 7'h40
  } csc_link_t;

  csc_xfer_if #(.W(16)) wr_x ();
  csc_xfer_if #(.W(16)) snap_x ();

  // link to registers: pointer and data of one written byte
  csc_cdc_word u_wr_cdc (
    .src_clk_i(LCLK_I),
    .src_rst_n_i(RST_N_I),
    .dst_clk_i(MCLK_I),
    .dst_rst_n_i(RST_N_I),
    .x(wr_x)
  );

  // registers to link: running copy of both registers
  csc_cdc_word u_snap_cdc (
    .src_clk_i(MCLK_I),
    .src_rst_n_i(RST_N_I),
    .dst_clk_i(LCLK_I),
    .dst_rst_n_i(RST_N_I),
    .x(snap_x)
  );

  // ---------------- link domain ----------------
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  csc_link_t lst_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, ptr_q, rd_byte;
  logic rw_q, first_q, oe_q, sda_o_q, wr_send_q;
  logic [15:0] wr_word_q, snap_q;

  // pins pass two flops; the third copy gives edges
  always_ff @(posedge LCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= SCL_I;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= SDA_I;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // bus events
  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_seen = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_seen = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

  // latest register copy from the register domain
  always_ff @(posedge LCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      snap_q <= {csc_pkg::CHARGER_CONTROL_ONE_RESET, 8'h00};
    end else if (snap_x.recv) begin
      snap_q <= snap_x.dst_data;
    end
  end

  // byte returned at the pointer
  always_comb begin
    if (ptr_q == csc_pkg::REG_STATUS) begin
      rd_byte = snap_q[7:0];
    end else if (ptr_q == csc_pkg::REG_CHARGER_CONTROL_ONE) begin
      rd_byte = snap_q[15:8];
    end else begin
      rd_byte = csc_pkg::UNMAPPED_READ;
    end
  end

  // link sequencer: address, acknowledge, write and read bytes
  always_ff @(posedge LCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lst_q <= L_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= csc_pkg::REG_STATUS;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      oe_q <= 1'b0;
      wr_send_q <= 1'b0;
      wr_word_q <= 16'h0000;
    end else begin
      wr_send_q <= 1'b0;
      if (start_seen) begin
        lst_q <= L_ADDR;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (stop_seen) begin
        lst_q <= L_IDLE;
        oe_q <= 1'b0;
      end else begin
        unique case (lst_q)
          L_IDLE: begin
            oe_q <= 1'b0;
          end
          L_ADDR, L_WBYTE: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == csc_pkg::BYTE_BITS) begin
              cnt_q <= 4'h0;
              if (lst_q == L_ADDR) begin
                if (sh_q[7:1] == SLAVE_ADDR) begin
                  lst_q <= L_AACK;
                  oe_q <= 1'b1;
                  rw_q <= sh_q[0];
                  first_q <= 1'b1;
                end else begin
                  lst_q <= L_IDLE;
                end
              end else begin
                lst_q <= L_WACK;
                oe_q <= 1'b1;
                first_q <= 1'b0;
                if (first_q) begin
                  ptr_q <= sh_q;
                end else begin
                  wr_word_q <= {ptr_q, sh_q};
                  wr_send_q <= 1'b1;
                  ptr_q <= ptr_q + csc_pkg::PTR_STEP;
                end
              end
            end
          end
          L_AACK, L_WACK: begin
            if (scl_fall) begin
              if (lst_q == L_AACK && rw_q) begin
                lst_q <= L_RBYTE;
                sh_q <= {rd_byte[6:0], 1'b0};
                oe_q <= !rd_byte[7];
                cnt_q <= 4'h1;
              end else begin
                lst_q <= L_WBYTE;
                oe_q <= 1'b0;
                cnt_q <= 4'h0;
              end
            end
          end
          L_RBYTE: begin
            if (scl_fall) begin
              if (cnt_q == csc_pkg::BYTE_BITS) begin
                lst_q <= L_RACK;
                oe_q <= 1'b0;
                ptr_q <= ptr_q + csc_pkg::PTR_STEP;
              end else begin
                oe_q <= !sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          L_RACK: begin
            if (scl_rise && sda_s_q) begin
              lst_q <= L_IDLE;
            end else if (scl_fall) begin
              lst_q <= L_RBYTE;
              sh_q <= {rd_byte[6:0], 1'b0};
              oe_q <= !rd_byte[7];
              cnt_q <= 4'h1;
            end
          end
        endcase
      end
    end
  end

  // data pin drive value is a constant low
  always_ff @(posedge LCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign SDA_O = sda_o_q;
  assign SDA_OE_O = oe_q;
  assign wr_x.send = wr_send_q;
  assign wr_x.src_data = wr_word_q;

  // ---------------- register domain ----------------
  logic otg_m_q, otg_s_q, otg_p_q, otg_rise;
  logic [7:0] ctl_q, stat_q;
  logic soft_rst_q, tchg_q, flag_q;
  logic ctl_wr;

  // boost pin passes two flops before edge detection
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      otg_m_q <= 1'b0;
      otg_s_q <= 1'b0;
      otg_p_q <= 1'b0;
    end else begin
      otg_m_q <= OTG_PIN_I;
      otg_s_q <= otg_m_q;
      otg_p_q <= otg_s_q;
    end
  end

  assign otg_rise = otg_s_q && !otg_p_q;
  assign ctl_wr = wr_x.recv && wr_x.dst_data[15:8] == csc_pkg::REG_CHARGER_CONTROL_ONE;

  // control register one
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctl_q <= csc_pkg::CHARGER_CONTROL_ONE_RESET;
      soft_rst_q <= 1'b0;
      tchg_q <= 1'b0;
    end else begin
      soft_rst_q <= 1'b0;
      tchg_q <= 1'b0;
      if (ctl_wr && wr_x.dst_data[csc_pkg::CTL_SOFT_RST]) begin
        ctl_q <= csc_pkg::CHARGER_CONTROL_ONE_RESET;
        soft_rst_q <= 1'b1;
      end else begin
        if (ctl_wr) begin
          // strobe bits are never stored, so the timer restart bit reads zero
          ctl_q <= wr_x.dst_data[7:0] & ~(8'h01 << csc_pkg::CTL_SOFT_RST)
            & ~(8'h01 << csc_pkg::CTL_TCHG_RST);
          tchg_q <= wr_x.dst_data[csc_pkg::CTL_TCHG_RST];
          if (!wr_x.dst_data[csc_pkg::CTL_CHARGE_EN]) begin
            ctl_q[csc_pkg::CTL_BOOST_REQ] <= 1'b0;
          end
        end
        if (otg_rise) begin
          ctl_q[csc_pkg::CTL_BOOST_REQ] <= 1'b1;
        end
      end
    end
  end

  // status register: state code and presence and summary bits
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stat_q <= 8'h00;
    end else begin
      if (!ctl_q[csc_pkg::CTL_CHARGE_EN] && STATE_I[3:2] != csc_pkg::BOOST_GROUP) begin
        stat_q[7:4] <= csc_pkg::CSC_FAULT;
      end else begin
        stat_q[7:4] <= STATE_I;
      end
      stat_q[csc_pkg::STAT_BATFET] <= BATFET_DET_I;
      stat_q[csc_pkg::STAT_NTC] <= NTC_DET_I;
      stat_q[csc_pkg::STAT_IRQ] <= STAT_IRQ_PEND_I;
      stat_q[csc_pkg::STAT_FAULT_IRQ] <= FAULT_IRQ_PEND_I;
    end
  end

  // interrupt output gated by the global mask
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= (STAT_IRQ_PEND_I || FAULT_IRQ_PEND_I) && !ctl_q[csc_pkg::CTL_IRQ_MASK];
    end
  end

  // offer the register copy whenever the crossing is free
  assign snap_x.send = 1'b1;
  assign snap_x.src_data = {ctl_q, stat_q};

  assign REGS_RST_O = soft_rst_q;
  assign CHARGE_EN_O = ctl_q[csc_pkg::CTL_CHARGE_EN];
  assign BOOST_REQ_O = ctl_q[csc_pkg::CTL_BOOST_REQ];
  assign NTC_EN_O = ctl_q[csc_pkg::CTL_NTC_EN];
  assign JUNC_DERATE_O = ctl_q[csc_pkg::CTL_JUNC_DERATE];
  assign WARM_REDUCE_O = ctl_q[csc_pkg::CTL_WARM_REDUCE];
  assign TCHG_RST_O = tchg_q;
  assign IRQ_MASK_O = ctl_q[csc_pkg::CTL_IRQ_MASK];
  assign FLAG_O = flag_q;

  // ---------------- checks ----------------
  property p_addr_miss;
    @(posedge LCLK_I) disable iff (!RST_N_I)
      (lst_q == L_ADDR && !start_seen && !stop_seen && scl_fall
       && cnt_q == csc_pkg::BYTE_BITS && sh_q[7:1] != SLAVE_ADDR)
      |=> (lst_q == L_IDLE && !oe_q);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");

  property p_read_dir;
    @(posedge LCLK_I) disable iff (!RST_N_I)
      (lst_q == L_AACK && rw_q && scl_fall && !start_seen && !stop_seen) |=> lst_q == L_RBYTE;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read bit did not select read");

  property p_ptr_load;
    @(posedge LCLK_I) disable iff (!RST_N_I)
      (lst_q == L_WBYTE && first_q && scl_fall && cnt_q == csc_pkg::BYTE_BITS
       && !start_seen && !stop_seen) |=> ptr_q == $past(sh_q);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_soft_reset;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (ctl_wr && wr_x.dst_data[csc_pkg::CTL_SOFT_RST])
      |=> (ctl_q == csc_pkg::CHARGER_CONTROL_ONE_RESET && REGS_RST_O) ##1 !REGS_RST_O;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

  property p_halt_fault;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (!ctl_q[csc_pkg::CTL_CHARGE_EN] && STATE_I[3:2] != csc_pkg::BOOST_GROUP)
      |=> stat_q[7:4] == csc_pkg::CSC_FAULT;
  endproperty
  a_halt_fault: assert property (p_halt_fault) else $error("halt did not report fault");

  property p_otg_pin;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (otg_rise && !(ctl_wr && wr_x.dst_data[csc_pkg::CTL_SOFT_RST])) |=> BOOST_REQ_O;
  endproperty
  a_otg_pin: assert property (p_otg_pin) else $error("boost pin ignored");

  property p_tchg_pulse;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (ctl_wr && !wr_x.dst_data[csc_pkg::CTL_SOFT_RST] && wr_x.dst_data[csc_pkg::CTL_TCHG_RST])
      |=> (TCHG_RST_O && !ctl_q[csc_pkg::CTL_TCHG_RST]) ##1 !TCHG_RST_O;
  endproperty
  a_tchg_pulse: assert property (p_tchg_pulse) else $error("timer restart not one pulse");

  property p_mask;
    @(posedge MCLK_I) disable iff (!RST_N_I) ctl_q[csc_pkg::CTL_IRQ_MASK] |=> !FLAG_O;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt signalled");

  property p_status_write;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (wr_x.recv && wr_x.dst_data[15:8] == csc_pkg::REG_STATUS && !otg_rise) |=> $stable(ctl_q);
  endproperty
  a_status_write: assert property (p_status_write) else $error("status write changed control");

  property p_batfet;
    @(posedge MCLK_I) disable iff (!RST_N_I) 1'b1 |=> stat_q[csc_pkg::STAT_BATFET] == $past(BATFET_DET_I);
  endproperty
  a_batfet: assert property (p_batfet) else $error("transistor presence bit wrong");

  c_soft_reset: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) soft_rst_q);
  c_read_byte: cover property (@(posedge LCLK_I) disable iff (!RST_N_I) lst_q == L_RACK);
  c_otg_pin: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) otg_rise);
  c_reg_write: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) ctl_wr);
endmodule

/* csc_host_model.sv */
/*
  two-wire bus master model that drives the charger register bank.
  assumes a pull-up on the data line and a slave that only pulls low.
*/
`timescale 1ns/1ps
module csc_host_model (
  output logic scl_o, // bus clock
  output logic sda_o, // master data drive, one releases
  input wire logic sda_i // resolved data line
);
  localparam int Q = 100; // quarter bit in ns, keeps clock low well past 8 link clocks

  // idle bus at time zero
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // start or repeated start, clock left low
  task automatic start();
    sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  // stop, bus left idle
  task automatic stop();
    sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask

  // eight bits and the acknowledge bit, most significant first
  task automatic byte_x(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_o = d[i];
      #Q scl_o = 1'b1;
      #Q r[i] = sda_i;
      #Q scl_o = 1'b0;
      #Q;
    end
  endtask
endmodule

/* tb_csc_regs.sv */
/*
  testbench for the charger register bank: control table, status sweep, hand tests.
  assumes csc_pkg, csc_regs and csc_host_model are compiled first.
*/
`timescale 1ns/1ps
module tb_csc_regs;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] state = 4'h0;
  logic [3:0] det = 4'h0;
  logic otg = 1'b0;
  wire logic scl, sda_m, sda_oe, sda_d, regs_rst, tchg_rst, flag;
  wire logic [5:0] outs;
  logic [8:0] rr;
  logic [7:0] d;
  int errors = 0;
  int total_checks = 0;
  int n_rr = 0;
  int n_tr = 0;
  localparam logic [13:0] ROWS [4] = '{{8'h7d, 6'h3f}, {8'h40, 6'h20}, {8'h0c, 6'h06},
    {8'h61, 6'h31}};
  wire logic sda = sda_m & (~sda_oe | sda_d); // pull-up, open drain

  // clocks: register 50 ns, link 12 ns with a phase offset
  always #25 mclk = ~mclk;
  initial #2 forever #6 lclk = ~lclk;

  csc_regs uut (.MCLK_I(mclk), .RST_N_I(rst_n), .LCLK_I(lclk), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_d), .SDA_OE_O(sda_oe), .STATE_I(state), .BATFET_DET_I(det[3]),
    .NTC_DET_I(det[2]), .STAT_IRQ_PEND_I(det[1]), .FAULT_IRQ_PEND_I(det[0]),
    .OTG_PIN_I(otg), .REGS_RST_O(regs_rst), .CHARGE_EN_O(outs[5]), .BOOST_REQ_O(outs[4]),
    .NTC_EN_O(outs[3]), .JUNC_DERATE_O(outs[2]), .WARM_REDUCE_O(outs[1]),
    .TCHG_RST_O(tchg_rst), .IRQ_MASK_O(outs[0]), .FLAG_O(flag));
  csc_host_model h (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));

  // count one-cycle pulses
  always @(posedge mclk) begin
    if (regs_rst === 1'b1) n_rr++;
    if (tchg_rst === 1'b1) n_tr++;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (20) @(negedge mclk);
  endtask

  // start plus address byte, low bit picks direction
  task automatic addr(input logic rd);
    h.start();
    h.byte_x({csc_pkg::SLAVE_ADDR, rd, 1'b1}, rr);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    addr(1'b0);
    h.byte_x({p, 1'b1}, rr);
    h.byte_x({v, 1'b1}, rr);
    h.stop();
    settle();
  endtask

  task automatic rd(input logic [7:0] p, input logic last, output logic [7:0] v);
    addr(1'b0);
    h.byte_x({p, 1'b1}, rr);
    addr(1'b1);
    h.byte_x({8'hff, last}, rr);
    v = rr[8:1];
    if (last) h.stop();
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #2000000;
    errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    settle();
    foreach (ROWS[i]) begin
      wr(csc_pkg::REG_CHARGER_CONTROL_ONE, ROWS[i][13:6]);
      rd(csc_pkg::REG_CHARGER_CONTROL_ONE, 1'b1, d);
      chk("ctrl", d, ROWS[i][13:6]);
      chk("outs", {2'h0, outs}, {2'h0, ROWS[i][5:0]});
    end
    for (int s = 0; s < 16; s++) begin
      if (s != 14) begin
        @(negedge mclk);
        state = 4'(s);
        det = 4'(s);
        settle();
        rd(csc_pkg::REG_STATUS, 1'b1, d);
        chk("status", d, {4'(s), 4'(s)});
        chk("flag", {7'h0, flag}, 8'h00);
      end
    end
    // burst write over status into control, then burst read
    @(negedge mclk);
    state = 4'h2;
    det = 4'h5;
    addr(1'b0);
    h.byte_x({csc_pkg::REG_STATUS, 1'b1}, rr);
    h.byte_x(9'h1ff, rr);
    chk("ack", {7'h0, rr[0]}, 8'h00);
    h.byte_x({8'h40, 1'b1}, rr);
    h.stop();
    settle();
    rd(csc_pkg::REG_STATUS, 1'b0, d);
    chk("status", d, 8'h25);
    h.byte_x(9'h1ff, rr);
    h.stop();
    chk("ctrl", rr[8:1], 8'h40);
    // halted charge reads as fault, boost codes pass through
    wr(csc_pkg::REG_CHARGER_CONTROL_ONE, 8'h30);
    rd(csc_pkg::REG_STATUS, 1'b1, d);
    chk("halt", d, 8'hb5);
    chk("outs", {2'h0, outs}, 8'h08);
    @(negedge mclk);
    state = 4'hd;
    settle();
    rd(csc_pkg::REG_STATUS, 1'b1, d);
    chk("boost", d, 8'hd5);
    // mask cleared lets the pending fault raise the flag
    wr(csc_pkg::REG_CHARGER_CONTROL_ONE, 8'h40);
    chk("flag", {7'h0, flag}, 8'h01);
    wr(csc_pkg::REG_CHARGER_CONTROL_ONE, 8'h41);
    chk("flag", {7'h0, flag}, 8'h00);
    n_tr = 0;
    wr(csc_pkg::REG_CHARGER_CONTROL_ONE, 8'h42);
    rd(csc_pkg::REG_CHARGER_CONTROL_ONE, 1'b1, d);
    chk("timer", d, 8'h40);
    chk("timer_pulse", 8'(n_tr), 8'h01);
    n_rr = 0;
    wr(csc_pkg::REG_CHARGER_CONTROL_ONE, 8'h80);
    rd(csc_pkg::REG_CHARGER_CONTROL_ONE, 1'b1, d);
    chk("soft_rst", d, 8'h51);
    chk("rst_pulse", 8'(n_rr), 8'h01);
    // boost pin rising edge sets the request
    @(negedge mclk);
    otg = 1'b1;
    settle();
    chk("pin", {7'h0, outs[4]}, 8'h01);
    otg = 1'b0;
    // foreign address gets no acknowledge
    h.start();
    h.byte_x({csc_pkg::SLAVE_ADDR ^ 7'h01, 1'b0, 1'b1}, rr);
    h.stop();
    chk("nack", {7'h0, rr[0]}, 8'h01);
    // reset in mid-run
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    chk("reset", {2'h0, outs}, 8'h29);
    chk("reset", {sda_oe, regs_rst, tchg_rst, flag, 4'h0}, 8'h00);
    rst_n = 1'b1;
    settle();
    rd(csc_pkg::REG_CHARGER_CONTROL_ONE, 1'b1, d);
    chk("reset", d, 8'h51);
    wrap_up();
  end
endmodule
